// ### disk_if_pkg.sv
// Function
// - An active write gate writes through the currently selected head only.
// - Six us after read gate rises, read/reference clock switches to the data oscillator.
// - With read gate inactive, read/reference clock comes from the servo reference.
// - Read data may be invalid for 9 us after read gate; controller ignores it.
// - Read data leaves as serial NRZ synchronised with the read/reference clock.
// - Write data is sampled on the write clock falling edge; controller holds it stable.
// - A switch chooses whether controller or drive sources the write clock.
// - Ready drops when a seek starts and returns on cylinder without fault.
// - Three low-active head lines decode heads zero to four; other codes pick zero.
// - Head-select lines act only while the drive is selected.
// - Writing between index and first sector mark raises drive fault.
// - Write errors (current, gate, ready, heads, transitions, protect) raise drive fault.
// - Spindle, reset when up, off-track when ready, restore or watchdog errors raise drive fault.
// - A low index pulse marks each pass of the servo index mark.
// - A low sector pulse marks each sector start; size chosen by switches.
// - Read, write and command activity is ignored unless drive select is active; a host reset while sequenced up raises drive fault even when deselected.
package disk_if_pkg;
    localparam int CLK_NS             = 50;
    localparam int SWITCH_NS          = 6000;
    localparam int SWITCH_CYC         = (SWITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_INVALID_NS    = 9000;
    localparam int READ_INVALID_CYC   = (READ_INVALID_NS + CLK_NS - 1) / CLK_NS;
    localparam int INDEX_PW_NS        = 2480;
    localparam int INDEX_PW_CYC       = (INDEX_PW_NS + CLK_NS - 1) / CLK_NS;
    localparam int SECTOR_PW_NS       = 1240;
    localparam int SECTOR_PW_CYC      = (SECTOR_PW_NS + CLK_NS - 1) / CLK_NS;
    localparam int FIRST_SECTOR_NS    = 44600;
    localparam int FIRST_SECTOR_CYC   = (FIRST_SECTOR_NS + CLK_NS - 1) / CLK_NS;
    localparam int BYTE_NS            = 1240;
    localparam int REF_HALF_CYC       = 2;
    localparam int WCUR_SETTLE_CYC    = 8;
    localparam int NO_TRANS_BITS      = 64;
    localparam logic [9:0] PIN_RST_VAL = 10'h3FF;

    typedef enum logic [1:0] {
        TRK_WAIT = 2'b00,
        TRK_LEAD = 2'b01,
        TRK_SECT = 2'b11
    } trk_state_type;

    function automatic logic [15:0] sector_bytes(input logic [1:0] sw);
        case (sw)
            2'h0:    sector_bytes = 16'h0100;
            2'h1:    sector_bytes = 16'h0200;
            2'h2:    sector_bytes = 16'h0400;
            default: sector_bytes = 16'h0800;
        endcase
    endfunction

    function automatic logic [4:0] head_onehot(input logic [2:0] code);
        head_onehot = 5'h01;
        if (code <= 3'h4) begin
            head_onehot = 5'(5'h01 << code);
        end
    endfunction
endpackage

// ### pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int           W       = 10,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// ### rrclk_gen.sv
`timescale 1ns/1ps
module rrclk_gen
    import disk_if_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic rg_act,
    input  wire logic head_data,
    output logic      rrclk_r,
    output logic      rr_rise_r,
    output logic      rr_fall_r,
    output logic      vfo_sel_r
);
    logic [3:0] ref_cnt_r;
    logic [3:0] vfo_cnt_r;
    logic [7:0] sw_cnt_r;
    logic       ref_clk_r;
    logic       vfo_clk_r;
    logic       data_d_r;
    logic       rr_nxt;

    // Servo-derived reference clock.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_cnt_r <= 4'h0;
            ref_clk_r <= 1'b0;
        end else if (ref_cnt_r == 4'(REF_HALF_CYC - 1)) begin
            ref_cnt_r <= 4'h0;
            ref_clk_r <= ~ref_clk_r;
        end else begin
            ref_cnt_r <= ref_cnt_r + 4'h1;
        end
    end

    // Data oscillator: tracks the reference when idle, realigns on each data edge.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vfo_cnt_r <= 4'h0;
            vfo_clk_r <= 1'b0;
            data_d_r  <= 1'b0;
        end else begin
            data_d_r <= head_data;
            if (!rg_act) begin
                vfo_cnt_r <= ref_cnt_r;
                vfo_clk_r <= ref_clk_r;
            end else if (data_d_r != head_data) begin
                vfo_cnt_r <= 4'h0;
                vfo_clk_r <= 1'b1;
            end else if (vfo_cnt_r == 4'(REF_HALF_CYC - 1)) begin
                vfo_cnt_r <= 4'h0;
                vfo_clk_r <= ~vfo_clk_r;
            end else begin
                vfo_cnt_r <= vfo_cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sw_cnt_r  <= 8'h00;
            vfo_sel_r <= 1'b0;
        end else begin
            if (!rg_act) begin
                sw_cnt_r <= 8'h00;
            end else if (sw_cnt_r < 8'(SWITCH_CYC)) begin
                sw_cnt_r <= sw_cnt_r + 8'h01;
            end
            vfo_sel_r <= rg_act && (sw_cnt_r >= 8'(SWITCH_CYC - 1));
        end
    end

    // A phase step at the switchover is accepted.
    assign rr_nxt = vfo_sel_r ? vfo_clk_r : ref_clk_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rrclk_r   <= 1'b0;
            rr_rise_r <= 1'b0;
            rr_fall_r <= 1'b0;
        end else begin
            rrclk_r   <= rr_nxt;
            rr_rise_r <= rr_nxt && !rrclk_r;
            rr_fall_r <= !rr_nxt && rrclk_r;
        end
    end
endmodule

// ### disk_if.sv
`timescale 1ns/1ps
module disk_if
    import disk_if_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       drive_sel_n,
    input  wire logic [2:0] head_sel_n,
    input  wire logic       write_gate_n,
    input  wire logic       read_gate_n,
    input  wire logic       write_data,
    input  wire logic       write_clk_in,
    input  wire logic       host_reset_n,
    input  wire logic       head_read_data,
    input  wire logic       wclk_from_drive,
    input  wire logic [1:0] sector_size_sw,
    input  wire logic       servo_index,
    input  wire logic       seek_start,
    input  wire logic       on_cylinder,
    input  wire logic       sequenced_up,
    input  wire logic       write_current,
    input  wire logic       multi_head,
    input  wire logic       write_protect,
    input  wire logic       spindle_err,
    input  wire logic       off_track,
    input  wire logic       restore_fail,
    input  wire logic       watchdog_expired,
    output logic            index_n_r,
    output logic            sector_n_r,
    output logic            ready_n_r,
    output logic            drive_fault_r,
    output logic [4:0]      head_en_r,
    output logic            write_en_r,
    output logic            enc_data_r,
    output logic            enc_strobe_r,
    output logic            read_ref_clk,
    output logic            read_data_r,
    output logic            read_valid_r,
    output logic            write_clk_out_r,
    output logic            write_clk_oe_n_r
);
    import disk_if_pkg::*;

    logic [9:0]    pins_s;
    logic          sel;
    logic [2:0]    head_s_n;
    logic          wg_act;
    logic          rg_act;
    logic          wd_s;
    logic          wclk_s;
    logic          hrst_s_n;
    logic          rd_s;
    logic          rr_rise;
    logic          rr_fall;
    logic          vfo_sel;
    logic          wclk_d_r;
    logic          hrst_d_r;
    logic          idx_d_r;
    logic          idx_rise;
    logic          samp_nxt;
    logic          ready_r;
    trk_state_type trk_r;
    logic [15:0]   lead_cnt_r;
    logic [15:0]   byte_acc_r;
    logic [15:0]   byte_cnt_r;
    logic          byte_tick;
    logic          sect_start;
    logic [7:0]    idx_pw_r;
    logic [7:0]    sect_pw_r;
    logic [7:0]    rv_cnt_r;
    logic [3:0]    wcur_cnt_r;
    logic [7:0]    notrans_cnt_r;
    logic          fault_set;

    pin_sync #(
        .W       (10),
        .RST_VAL (PIN_RST_VAL)
    ) u_sync (
        .clk (sys_clk),
        .rst (rst),
        .d   ({drive_sel_n, head_sel_n, write_gate_n, read_gate_n, write_data,
               write_clk_in, host_reset_n, head_read_data}),
        .q   (pins_s)
    );

    assign sel      = !pins_s[9];
    assign head_s_n = pins_s[8:6];
    assign wg_act   = sel && !pins_s[5];
    assign rg_act   = sel && !pins_s[4];
    assign wd_s     = pins_s[3];
    assign wclk_s   = pins_s[2];
    assign hrst_s_n = pins_s[1];
    assign rd_s     = pins_s[0];

    rrclk_gen u_rrclk (
        .clk       (sys_clk),
        .rst       (rst),
        .rg_act    (rg_act),
        .head_data (rd_s),
        .rrclk_r   (read_ref_clk),
        .rr_rise_r (rr_rise),
        .rr_fall_r (rr_fall),
        .vfo_sel_r (vfo_sel)
    );

    // Head selection is latched only while the drive is selected.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            head_en_r <= 5'h01;
        end else if (sel) begin
            head_en_r <= head_onehot(~head_s_n);
        end
    end

    // Write path: sampling edge is the falling edge of whichever write clock is in use.
    assign samp_nxt = wclk_from_drive ? rr_fall : (wclk_d_r && !wclk_s);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wclk_d_r         <= 1'b1;
            enc_data_r       <= 1'b0;
            enc_strobe_r     <= 1'b0;
            write_en_r       <= 1'b0;
            write_clk_out_r  <= 1'b0;
            write_clk_oe_n_r <= 1'b1;
        end else begin
            wclk_d_r         <= wclk_s;
            write_en_r       <= wg_act && ready_r && !drive_fault_r;
            enc_strobe_r     <= wg_act && samp_nxt;
            if (wg_act && samp_nxt) begin
                enc_data_r <= wd_s;
            end
            write_clk_out_r  <= read_ref_clk;
            write_clk_oe_n_r <= !wclk_from_drive;
        end
    end

    // Read path: data changes on the falling edge so the controller samples on the rise.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            read_data_r  <= 1'b0;
            read_valid_r <= 1'b0;
            rv_cnt_r     <= 8'h00;
        end else begin
            if (!rg_act) begin
                read_data_r <= 1'b0;
            end else if (rr_fall) begin
                read_data_r <= rd_s;
            end
            if (!rg_act) begin
                rv_cnt_r <= 8'h00;
            end else if (rv_cnt_r < 8'(READ_INVALID_CYC)) begin
                rv_cnt_r <= rv_cnt_r + 8'h01;
            end
            read_valid_r <= rg_act && (rv_cnt_r >= 8'(READ_INVALID_CYC - 1));
        end
    end

    // Track position: leader from index to first sector, then fixed sectors.
    assign idx_rise  = servo_index && !idx_d_r;
    assign byte_tick = (trk_r == TRK_SECT) && (byte_acc_r >= 16'(BYTE_NS - CLK_NS));
    assign sect_start = ((trk_r == TRK_LEAD) && (lead_cnt_r == 16'(FIRST_SECTOR_CYC - 1)))
                     || (byte_tick && (byte_cnt_r == sector_bytes(sector_size_sw) - 16'h0001));

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            idx_d_r    <= 1'b0;
            trk_r      <= TRK_WAIT;
            lead_cnt_r <= 16'h0000;
            byte_acc_r <= 16'h0000;
            byte_cnt_r <= 16'h0000;
        end else begin
            idx_d_r <= servo_index;
            if (idx_rise) begin
                trk_r      <= TRK_LEAD;
                lead_cnt_r <= 16'h0000;
            end else begin
                unique case (trk_r)
                    TRK_WAIT: begin
                        lead_cnt_r <= 16'h0000;
                    end
                    TRK_LEAD: begin
                        lead_cnt_r <= lead_cnt_r + 16'h0001;
                        if (sect_start) begin
                            trk_r      <= TRK_SECT;
                            byte_acc_r <= 16'h0000;
                            byte_cnt_r <= 16'h0000;
                        end
                    end
                    TRK_SECT: begin
                        if (byte_tick) begin
                            byte_acc_r <= byte_acc_r + 16'(CLK_NS) - 16'(BYTE_NS);
                            byte_cnt_r <= sect_start ? 16'h0000 : byte_cnt_r + 16'h0001;
                        end else begin
                            byte_acc_r <= byte_acc_r + 16'(CLK_NS);
                        end
                    end
                    default: begin
                        trk_r <= TRK_WAIT;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            idx_pw_r   <= 8'h00;
            sect_pw_r  <= 8'h00;
            index_n_r  <= 1'b1;
            sector_n_r <= 1'b1;
        end else begin
            if (idx_rise) begin
                idx_pw_r <= 8'(INDEX_PW_CYC - 1);
            end else if (idx_pw_r != 8'h00) begin
                idx_pw_r <= idx_pw_r - 8'h01;
            end
            if (sect_start && !idx_rise) begin
                sect_pw_r <= 8'(SECTOR_PW_CYC - 1);
            end else if (sect_pw_r != 8'h00) begin
                sect_pw_r <= sect_pw_r - 8'h01;
            end
            index_n_r  <= !(idx_rise || idx_pw_r != 8'h00);
            sector_n_r <= !((sect_start && !idx_rise) || sect_pw_r != 8'h00);
        end
    end

    // Ready handling around seeks.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ready_r   <= 1'b0;
            ready_n_r <= 1'b1;
        end else begin
            if (seek_start || !sequenced_up || drive_fault_r) begin
                ready_r <= 1'b0;
            end else if (on_cylinder) begin
                ready_r <= 1'b1;
            end
            ready_n_r <= !(ready_r && sel);
        end
    end

    // Fault monitors: write current mismatch beyond a settle time, and a stuck data stream.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wcur_cnt_r    <= 4'h0;
            notrans_cnt_r <= 8'h00;
            hrst_d_r      <= 1'b1;
        end else begin
            hrst_d_r <= hrst_s_n;
            if (wg_act == write_current) begin
                wcur_cnt_r <= 4'h0;
            end else if (wcur_cnt_r < 4'(WCUR_SETTLE_CYC)) begin
                wcur_cnt_r <= wcur_cnt_r + 4'h1;
            end
            if (!wg_act) begin
                notrans_cnt_r <= 8'h00;
            end else if (wg_act && samp_nxt) begin
                notrans_cnt_r <= (wd_s != enc_data_r) ? 8'h00 : notrans_cnt_r + 8'h01;
            end
        end
    end

    assign fault_set = (wg_act && (!ready_r || trk_r == TRK_LEAD))
                    || (wg_act && (write_protect || multi_head))
                    || (wcur_cnt_r == 4'(WCUR_SETTLE_CYC))
                    || (notrans_cnt_r >= 8'(NO_TRANS_BITS))
                    || spindle_err || restore_fail || watchdog_expired
                    || (off_track && ready_r)
                    || (hrst_d_r && !hrst_s_n && sequenced_up);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            drive_fault_r <= 1'b0;
        end else if (fault_set) begin
            drive_fault_r <= 1'b1;
        end
    end

    a_ref_when_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !rg_act |=> !vfo_sel)
        else $error("Read clock not on reference while read gate idle.");
    a_vfo_switch_time: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(vfo_sel) |-> rg_act && $past(rg_act, 120) && !$past(rg_act, 121))
        else $error("Data clock switch not six microseconds after read gate.");
    a_read_invalid_win: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(rg_act) |=> !read_valid_r [*8] ##172 (read_valid_r || !rg_act))
        else $error("Read valid timing wrong.");
    a_ready_on_seek: assert property (@(posedge sys_clk) disable iff (rst)
        seek_start |=> !ready_r ##1 !ready_n_r == 1'b0)
        else $error("Ready not dropped by seek.");
    a_head_default: assert property (@(posedge sys_clk) disable iff (rst)
        sel && (head_s_n[2] == 1'b0) && (head_s_n[1:0] != 2'b11) |=> head_en_r == 5'h01)
        else $error("Out of range head code did not select head zero.");
    a_head_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !sel |=> $stable(head_en_r))
        else $error("Head selection changed while deselected.");
    a_write_one_head: assert property (@(posedge sys_clk) disable iff (rst)
        write_en_r |-> $past(wg_act) && $onehot(head_en_r))
        else $error("Write enabled without gate or single head.");
    a_leader_fault: assert property (@(posedge sys_clk) disable iff (rst)
        wg_act && trk_r == TRK_LEAD |=> drive_fault_r)
        else $error("Write in leader did not fault.");
    a_fault_latched: assert property (@(posedge sys_clk) disable iff (rst)
        drive_fault_r |=> drive_fault_r)
        else $error("Drive fault cleared without reset.");
    a_unselected_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        !sel |=> !enc_strobe_r && !read_valid_r)
        else $error("Activity while drive not selected.");
    a_index_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        idx_rise |=> !index_n_r [*8])
        else $error("Index pulse too short.");

    c_vfo_switch: cover property (@(posedge sys_clk) disable iff (rst) $rose(vfo_sel));
    c_sector_mark: cover property (@(posedge sys_clk) disable iff (rst) $fell(sector_n_r));
    c_enc_strobe: cover property (@(posedge sys_clk) disable iff (rst) enc_strobe_r);
    c_fault: cover property (@(posedge sys_clk) disable iff (rst) $rose(drive_fault_r));
endmodule

// ### disk_ctrl_model.sv
`timescale 1ns/1ps
module disk_ctrl_model (
    input  wire logic read_ref_clk,
    output logic      write_data,
    output logic      write_clk_in,
    output logic      last_bit
);
    logic [7:0] pat_r;

    initial begin
        pat_r        = 8'hB4;
        write_data   = 1'b0;
        write_clk_in = 1'b0;
        last_bit     = 1'b0;
    end

    // The echo path carries the same delay as the data path.
    always @(read_ref_clk) write_clk_in <= #10 read_ref_clk;

    always @(posedge read_ref_clk) begin
        write_data <= #10 pat_r[7];
        pat_r      <= {pat_r[6:0], pat_r[7]};
    end

    // Data moves only after rising edges, so it is stable across each falling edge.
    always @(negedge write_clk_in) last_bit = write_data;
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import disk_if_pkg::*;
    logic       sys_clk, rst, drive_sel_n, write_gate_n, read_gate_n, write_data, write_clk_in;
    logic       host_reset_n, head_read_data, wclk_from_drive, servo_index, seek_start;
    logic       on_cylinder, sequenced_up, write_current, multi_head, write_protect;
    logic       spindle_err, off_track, restore_fail, watchdog_expired, last_bit;
    logic [2:0] head_sel_n;
    logic [1:0] sector_size_sw;
    logic       index_n_r, sector_n_r, ready_n_r, drive_fault_r, write_en_r, enc_data_r;
    logic       enc_strobe_r, read_ref_clk, read_data_r, read_valid_r, write_clk_out_r;
    logic       write_clk_oe_n_r;
    logic [4:0] head_en_r;
    int         n_errors = 0;
    int         n_tests  = 0;

    disk_if disk_if_i (.sys_clk(sys_clk), .rst(rst), .drive_sel_n(drive_sel_n),
        .head_sel_n(head_sel_n), .write_gate_n(write_gate_n), .read_gate_n(read_gate_n),
        .write_data(write_data), .write_clk_in(write_clk_in), .host_reset_n(host_reset_n),
        .head_read_data(head_read_data), .wclk_from_drive(wclk_from_drive),
        .sector_size_sw(sector_size_sw), .servo_index(servo_index), .seek_start(seek_start),
        .on_cylinder(on_cylinder), .sequenced_up(sequenced_up), .write_current(write_current),
        .multi_head(multi_head), .write_protect(write_protect), .spindle_err(spindle_err),
        .off_track(off_track), .restore_fail(restore_fail),
        .watchdog_expired(watchdog_expired), .index_n_r(index_n_r), .sector_n_r(sector_n_r),
        .ready_n_r(ready_n_r), .drive_fault_r(drive_fault_r), .head_en_r(head_en_r),
        .write_en_r(write_en_r), .enc_data_r(enc_data_r), .enc_strobe_r(enc_strobe_r),
        .read_ref_clk(read_ref_clk), .read_data_r(read_data_r), .read_valid_r(read_valid_r),
        .write_clk_out_r(write_clk_out_r), .write_clk_oe_n_r(write_clk_oe_n_r));

    disk_ctrl_model disk_ctrl_model_i (.read_ref_clk(read_ref_clk), .write_data(write_data),
        .write_clk_in(write_clk_in), .last_bit(last_bit));

    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    task automatic test_done;
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        while (s !== v && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic do_reset;
        rst = 1'b1;
        cyc(4);
        rst = 1'b0;
        cyc(4);
    endtask

    task automatic t_reset;
        chk({index_n_r, sector_n_r, ready_n_r, drive_fault_r, write_clk_oe_n_r}, 5'h1D);
        chk(head_en_r, 5'h01);
        wclk_from_drive = 1'b1;
        cyc(3);
        chk(write_clk_oe_n_r, 1'b0);
        wclk_from_drive = 1'b0;
        cyc(3);
        chk(write_clk_oe_n_r, 1'b1);
    endtask

    task automatic t_heads;
        drive_sel_n = 1'b0;
        for (int c = 0; c < 8; c++) begin
            head_sel_n = ~3'(c);
            cyc(5);
            chk(head_en_r, (c <= 4) ? 5'(5'h01 << c) : 5'h01);
        end
        drive_sel_n = 1'b1;
        head_sel_n  = ~3'h4;
        cyc(5);
        chk(head_en_r === 5'h10, 1'b0);
        drive_sel_n = 1'b0;
        cyc(5);
        chk(head_en_r, 5'h10);
    endtask

    task automatic t_ready;
        int n;
        sequenced_up = 1'b1;
        on_cylinder  = 1'b1;
        wait_for(ready_n_r, 1'b0, 10, n);
        chk(n < 10, 1'b1);
        seek_start  = 1'b1;
        on_cylinder = 1'b0;
        cyc(1);
        seek_start = 1'b0;
        cyc(2);
        chk(ready_n_r, 1'b1);
        cyc(20);
        chk(ready_n_r, 1'b1);
        on_cylinder = 1'b1;
        wait_for(ready_n_r, 1'b0, 6, n);
        chk(n < 6, 1'b1);
    endtask

    task automatic t_track;
        int n, w, s;
        servo_index = 1'b1;
        wait_for(index_n_r, 1'b0, 5, n);
        servo_index = 1'b0;
        chk(n < 5, 1'b1);
        wait_for(index_n_r, 1'b1, 60, w);
        chk(16'(w), 16'(INDEX_PW_CYC));
        wait_for(sector_n_r, 1'b0, 1000, s);
        chk(w + s >= FIRST_SECTOR_CYC - 2 && w + s <= FIRST_SECTOR_CYC, 1'b1);
        wait_for(sector_n_r, 1'b1, 40, w);
        chk(16'(w), 16'(SECTOR_PW_CYC));
        wait_for(sector_n_r, 1'b0, 7000, s);
        n = 256 * BYTE_NS / CLK_NS;
        chk(w + s >= n && w + s <= n + 1, 1'b1);
        sector_size_sw = 2'h1;
        wait_for(sector_n_r, 1'b1, 40, w);
        wait_for(sector_n_r, 1'b0, 14000, s);
        n = 512 * BYTE_NS / CLK_NS;
        chk(w + s >= n && w + s <= n + 1, 1'b1);
        sector_size_sw = 2'h0;
    endtask

    task automatic t_write;
        int n;
        for (int m = 0; m < 2; m++) begin
            wclk_from_drive = m[0];
            cyc(3);
            write_gate_n  = 1'b0;
            write_current = 1'b1;
            wait_for(write_en_r, 1'b1, 8, n);
            chk(n < 8, 1'b1);
            for (int k = 0; k < 8; k++) begin
                wait_for(enc_strobe_r, 1'b1, 10, n);
                chk(n < 10, 1'b1);
                chk(enc_data_r, last_bit);
                chk(head_en_r, 5'h10);
                cyc(1);
            end
            write_gate_n  = 1'b1;
            write_current = 1'b0;
            cyc(6);
            chk({write_en_r, drive_fault_r}, 2'h0);
        end
        wclk_from_drive = 1'b0;
    endtask

    task automatic t_read;
        int a, b, ch;
        logic r1, r2, pd;
        wait_for(read_ref_clk, 1'b0, 8, a);
        wait_for(read_ref_clk, 1'b1, 8, a);
        wait_for(read_ref_clk, 1'b0, 8, a);
        wait_for(read_ref_clk, 1'b1, 8, b);
        chk(16'(a + b), 16'(2 * REF_HALF_CYC));
        chk(read_data_r, 1'b0);
        drive_sel_n = 1'b1;
        read_gate_n = 1'b0;
        cyc(200);
        chk(read_valid_r, 1'b0);
        read_gate_n = 1'b1;
        drive_sel_n = 1'b0;
        cyc(4);
        read_gate_n = 1'b0;
        cyc(176);
        chk(read_valid_r, 1'b0);
        wait_for(read_valid_r, 1'b1, 10, a);
        chk(a < 10, 1'b1);
        ch = 0;
        r1 = read_ref_clk;
        r2 = read_ref_clk;
        pd = read_data_r;
        for (int i = 0; i < 120; i++) begin
            @(negedge sys_clk);
            if (i % 6 == 0) head_read_data = ~head_read_data;
            if (read_data_r !== pd) begin
                ch++;
                chk({r2, r1}, 2'h2);
            end
            chk(write_clk_out_r, r1);
            pd = read_data_r;
            r2 = r1;
            r1 = read_ref_clk;
        end
        chk(ch > 0, 1'b1);
        read_gate_n = 1'b1;
        cyc(6);
        chk({read_valid_r, read_data_r}, 2'h0);
    endtask

    task automatic t_leader;
        int n;
        servo_index = 1'b1;
        wait_for(index_n_r, 1'b0, 5, n);
        servo_index = 1'b0;
        cyc(100);
        write_gate_n  = 1'b0;
        write_current = 1'b1;
        cyc(10);
        chk(drive_fault_r, 1'b1);
        write_gate_n  = 1'b1;
        write_current = 1'b0;
        cyc(50);
        chk(drive_fault_r, 1'b1);
        do_reset();
        chk(drive_fault_r, 1'b0);
    endtask

    task automatic t_faults;
        int n;
        for (int k = 0; k < 9; k++) begin
            do_reset();
            sequenced_up = (k != 8);
            cyc(10);
            chk(drive_fault_r, 1'b0);
            case (k)
                0: spindle_err = 1'b1;
                1: restore_fail = 1'b1;
                2: watchdog_expired = 1'b1;
                3: off_track = 1'b1;
                4: host_reset_n = 1'b0;
                5: write_current = 1'b1;
                6: {multi_head, write_gate_n, write_current} = 3'h5;
                7: {write_protect, write_gate_n, write_current} = 3'h5;
                default: {write_gate_n, write_current} = 2'h1;
            endcase
            wait_for(drive_fault_r, 1'b1, 20, n);
            chk(n < 20, 1'b1);
            {spindle_err, restore_fail, watchdog_expired, off_track, multi_head} = 5'h00;
            {write_protect, write_gate_n, write_current, host_reset_n} = 4'h5;
        end
        do_reset();
    endtask

    initial begin
        #(40000 * 50);
        n_errors++;
        test_done();
    end

    initial begin
        rst = 1'b1;
        {drive_sel_n, write_gate_n, read_gate_n, host_reset_n} = 4'hF;
        {head_read_data, wclk_from_drive, servo_index, seek_start} = 4'h0;
        {on_cylinder, sequenced_up, write_current, multi_head, write_protect} = 5'h00;
        {spindle_err, off_track, restore_fail, watchdog_expired} = 4'h0;
        head_sel_n     = 3'h7;
        sector_size_sw = 2'h0;
        cyc(4);
        rst = 1'b0;
        cyc(4);
        t_reset();
        t_heads();
        t_ready();
        t_track();
        t_write();
        t_read();
        t_leader();
        t_faults();
        test_done();
    end
endmodule
